// File: hw/rasu_defines.vh
// Constants for the return address stack unit
// Notes on behaviour
// - Program counter is 21 bits; fetches beyond implemented memory return zero words.
// - Reset starts at 0000h; interrupts vector to 0008h high, 0018h low.
// - Calls and interrupt acknowledge push the program counter.
// - Return, return-with-literal and return-from-interrupt load the counter from top entry.
// - Calls and returns leave the upper and high counter latches untouched.
// - Storage is 31 entries of 21 bits; resets clear pointer; entry zero absent.
// - Push increments the pointer, then writes the counter at the new pointer.
// - Pop copies the selected entry to the counter, then decrements the pointer.
// - Top entry upper, high, low show the selected entry; writes modify it.
// - Full flag sets after 31 pushes; only software or power-on clears it.
// - With fault reset on, 31st push stores PC+2, sets full, resets, pointer 0.
// - With fault reset off, 31st push sets full, pointer 31; later pushes ignored.
// - Pop at pointer zero loads zero, sets underflow, pointer stays zero.
// - Fault reset on: underflow also resets device; off: flags only.
// - Pointer register: full bit 7, underflow bit 6, bit 5 zero, pointer 4-0.
// - Push instruction stores current counter in new top entry, flow unchanged.
// - Pop instruction only decrements the pointer, counter not loaded.
// - Every interrupt vectoring copies status, working and bank select to shadow store.
// - Fast return from interrupt restores the three registers from shadow store.
// - High priority interrupt during low priority service overwrites the shadow values.
// - Fast call saves the three registers into the shadow store.
`ifndef RASU_DEFINES_VH
`define RASU_DEFINES_VH
`define RASU_OFF_PTR 5'h00
`define RASU_OFF_TOP_UPPER 5'h04
`define RASU_OFF_TOP_HIGH 5'h08
`define RASU_OFF_TOP_LOW 5'h0c
`define RASU_OFF_CFG 5'h10
`define RASU_FULL_BIT 7
`define RASU_UNF_BIT 6
`define RASU_CFG_EN_BIT 0
`define RASU_CFG_RESET 1'b1
`define RASU_PTR_RESET 5'h00
`define RASU_PTR_MAX 5'h1f
`define RASU_PTR_LAST_FREE 5'h1e
`define RASU_VEC_RESET 21'h000000
`define RASU_VEC_HIGH 21'h000008
`define RASU_VEC_LOW 21'h000018
`define RASU_PC_STEP 21'h000002
`define RASU_IMPL_BYTES 21'h008000
`endif

// File: hw/rasu_shadow.v
// One-deep shadow store for status, working and bank select registers
`timescale 1ns/1ps
module rasu_shadow (
   input wire i_sys_clk,
   input wire i_reset_n,
   input wire i_save,
   input wire i_restore,
   input wire [7:0] i_status,
   input wire [7:0] i_working_register,
   input wire [7:0] i_bsr,
   output reg o_restore_r,
   output reg [7:0] o_status_r,
   output reg [7:0] o_working_register_r,
   output reg [7:0] o_bsr_r
);
   reg [7:0] sh_status_r;
   reg [7:0] sh_working_register_r;
   reg [7:0] sh_bsr_r;

   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         sh_status_r <= 8'h00;
         sh_working_register_r <= 8'h00;
         sh_bsr_r <= 8'h00;
         o_restore_r <= 1'b0;
         o_status_r <= 8'h00;
         o_working_register_r <= 8'h00;
         o_bsr_r <= 8'h00;
      end else begin
         // Any save overwrites, no nesting protection
         if (i_save) begin
            sh_status_r <= i_status;
            sh_working_register_r <= i_working_register;
            sh_bsr_r <= i_bsr;
         end
         o_restore_r <= i_restore;
         if (i_restore) begin
            o_status_r <= sh_status_r;
            o_working_register_r <= sh_working_register_r;
            o_bsr_r <= sh_bsr_r;
         end
      end
   end
endmodule

// File: hw/rasu_stack_mem.v
// Return stack storage, entries 1..DEPTH, index zero reads as zero
`timescale 1ns/1ps
module rasu_stack_mem #(
   parameter DEPTH = 31,
   parameter WIDTH = 21,
   parameter PTR_W = 5
) (
   input wire i_sys_clk,
   input wire i_we,
   input wire [PTR_W-1:0] i_idx,
   input wire [WIDTH-1:0] i_wdata,
   output wire [WIDTH-1:0] o_rdata
);
   reg [WIDTH-1:0] mem_r [1:DEPTH];

   // No storage behind index zero
   assign o_rdata = (i_idx == {PTR_W{1'b0}}) ? {WIDTH{1'b0}} : mem_r[i_idx];

   always @(posedge i_sys_clk) begin
      if (i_we && i_idx != {PTR_W{1'b0}}) begin
         mem_r[i_idx] <= i_wdata;
      end
   end
endmodule

// File: hw/rasu_top.v
// Return address stack unit with pointer/status registers on Avalon-MM
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "rasu_defines.vh"
module rasu_top #(
   parameter DEPTH = 31,
   parameter PC_W = 21,
   parameter PTR_W = 5,
   parameter [20:0] IMPL_BYTES = `RASU_IMPL_BYTES
) (
   input wire i_sys_clk,
   input wire i_reset_n,
   input wire i_dev_reset,
   input wire [4:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   input wire i_push_call,
   input wire i_push_int,
   input wire i_int_high,
   input wire i_push_instr,
   input wire i_pop_ret,
   input wire i_pop_instr,
   input wire i_fast,
   input wire [20:0] i_pc,
   input wire [7:0] i_status,
   input wire [7:0] i_working_register,
   input wire [7:0] i_bsr,
   input wire [20:0] i_fetch_addr,
   input wire [15:0] i_fetch_word,
   output reg [15:0] o_fetch_word,
   output reg o_pc_load,
   output reg [20:0] o_pc_value,
   output reg o_stack_reset,
   output wire o_restore,
   output wire [7:0] o_status,
   output wire [7:0] o_working_register,
   output wire [7:0] o_bsr
);
   reg [PTR_W-1:0] ptr_r;
   reg full_r;
   reg unf_r;
   reg fault_en_r;
   reg mem_we;
   reg [PTR_W-1:0] mem_idx;
   reg [PC_W-1:0] mem_wd;
   reg [7:0] rd_mux;
   wire [PC_W-1:0] tos;
   wire push_any;
   wire pop_any;
   wire bus_wr;
   wire ptr_zero;
   wire ptr_top;
   wire sw_top_wr;

   assign push_any = i_push_call | i_push_int | i_push_instr;
   assign pop_any = i_pop_ret | i_pop_instr;
   assign ptr_zero = (ptr_r == `RASU_PTR_RESET);
   assign ptr_top = (ptr_r == `RASU_PTR_MAX);

   // Write commits in the cycle waitrequest is low
   assign bus_wr = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
   assign sw_top_wr = bus_wr & ((i_avs_address == `RASU_OFF_TOP_UPPER) |
                                (i_avs_address == `RASU_OFF_TOP_HIGH) |
                                (i_avs_address == `RASU_OFF_TOP_LOW));

   rasu_stack_mem #(
      .DEPTH(DEPTH),
      .WIDTH(PC_W),
      .PTR_W(PTR_W)
   ) u_mem (
      .i_sys_clk(i_sys_clk),
      .i_we(mem_we),
      .i_idx(mem_idx),
      .i_wdata(mem_wd),
      .o_rdata(tos)
   );

   // Interrupt vectoring and fast calls save; fast return restores
   rasu_shadow u_shadow (
      .i_sys_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .i_save(i_push_int | (i_push_call & i_fast)),
      .i_restore(i_pop_ret & i_fast),
      .i_status(i_status),
      .i_working_register(i_working_register),
      .i_bsr(i_bsr),
      .o_restore_r(o_restore),
      .o_status_r(o_status),
      .o_working_register_r(o_working_register),
      .o_bsr_r(o_bsr)
   );

   // Storage write port: push first, else software top-entry write
   always @* begin
      mem_we = 1'b0;
      mem_idx = ptr_r;
      mem_wd = i_pc;
      if (push_any) begin
         mem_idx = ptr_r + 5'h01;
         mem_we = ~ptr_top;
         if (ptr_r == `RASU_PTR_LAST_FREE && fault_en_r) begin
            mem_wd = i_pc + `RASU_PC_STEP;
         end else begin
            mem_wd = i_pc;
         end
      end else if (sw_top_wr && !ptr_zero) begin
         mem_we = 1'b1;
         mem_idx = ptr_r;
         case (i_avs_address)
            `RASU_OFF_TOP_UPPER: begin
               mem_wd = {i_avs_writedata[4:0], tos[15:0]};
            end
            `RASU_OFF_TOP_HIGH: begin
               mem_wd = {tos[20:16], i_avs_writedata[7:0], tos[7:0]};
            end
            default: begin
               mem_wd = {tos[20:8], i_avs_writedata[7:0]};
            end
         endcase
      end
   end

   // Register read mux, unmapped reads zero
   always @* begin
      case (i_avs_address)
         `RASU_OFF_PTR: begin
            rd_mux = {full_r, unf_r, 1'b0, ptr_r};
         end
         `RASU_OFF_TOP_UPPER: begin
            rd_mux = {3'h0, tos[20:16]};
         end
         `RASU_OFF_TOP_HIGH: begin
            rd_mux = tos[15:8];
         end
         `RASU_OFF_TOP_LOW: begin
            rd_mux = tos[7:0];
         end
         `RASU_OFF_CFG: begin
            rd_mux = {7'h00, fault_en_r};
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // Avalon slave: one wait state per access
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h00000000;
      end else if (!o_avs_waitrequest) begin
         o_avs_waitrequest <= 1'b1;
      end else if (i_avs_read || i_avs_write) begin
         o_avs_waitrequest <= 1'b0;
         if (i_avs_read) begin
            o_avs_readdata <= {24'h000000, rd_mux};
         end
      end
   end

   // Fault reset option, set by default
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         fault_en_r <= `RASU_CFG_RESET;
      end else if (bus_wr && i_avs_address == `RASU_OFF_CFG) begin
         fault_en_r <= i_avs_writedata[`RASU_CFG_EN_BIT];
      end
   end

   // Flags: cleared by power-on or software zero write; set wins
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         full_r <= 1'b0;
         unf_r <= 1'b0;
      end else begin
         if (push_any && (ptr_r == `RASU_PTR_LAST_FREE || ptr_top)) begin
            full_r <= 1'b1;
         end else if (bus_wr && i_avs_address == `RASU_OFF_PTR && !i_avs_writedata[`RASU_FULL_BIT]) begin
            full_r <= 1'b0;
         end
         if (!push_any && pop_any && ptr_zero) begin
            unf_r <= 1'b1;
         end else if (bus_wr && i_avs_address == `RASU_OFF_PTR && !i_avs_writedata[`RASU_UNF_BIT]) begin
            unf_r <= 1'b0;
         end
      end
   end

   // Stack pointer and stack fault reset request
   always @(posedge i_sys_clk) begin
      if (!i_reset_n || i_dev_reset) begin
         ptr_r <= `RASU_PTR_RESET;
         o_stack_reset <= 1'b0;
      end else begin
         o_stack_reset <= 1'b0;
         if (o_stack_reset) begin
            ptr_r <= `RASU_PTR_RESET;
         end else if (push_any) begin
            if (ptr_top) begin
               o_stack_reset <= fault_en_r;
            end else if (ptr_r == `RASU_PTR_LAST_FREE && fault_en_r) begin
               ptr_r <= `RASU_PTR_RESET;
               o_stack_reset <= 1'b1;
            end else begin
               ptr_r <= ptr_r + 5'h01;
            end
         end else if (pop_any) begin
            if (ptr_zero) begin
               o_stack_reset <= fault_en_r;
            end else begin
               ptr_r <= ptr_r - 5'h01;
            end
         end else if (bus_wr && i_avs_address == `RASU_OFF_PTR) begin
            ptr_r <= i_avs_writedata[4:0];
         end
      end
   end

   // Program counter load toward the sequencer; latches are bypassed
   always @(posedge i_sys_clk) begin
      if (!i_reset_n || i_dev_reset) begin
         o_pc_load <= 1'b0;
         o_pc_value <= `RASU_VEC_RESET;
      end else begin
         o_pc_load <= 1'b0;
         if (o_stack_reset) begin
            o_pc_load <= 1'b1;
            o_pc_value <= `RASU_VEC_RESET;
         end else if (i_push_int) begin
            o_pc_load <= 1'b1;
            o_pc_value <= i_int_high ? `RASU_VEC_HIGH : `RASU_VEC_LOW;
         end else if (!push_any && i_pop_ret) begin
            o_pc_load <= 1'b1;
            o_pc_value <= ptr_zero ? `RASU_VEC_RESET : tos;
         end
      end
   end

   // Fetch filter: beyond implemented memory reads as zero
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_fetch_word <= 16'h0000;
      end else if (i_fetch_addr < IMPL_BYTES) begin
         o_fetch_word <= i_fetch_word;
      end else begin
         o_fetch_word <= 16'h0000;
      end
   end
endmodule

// File: verif/rasu_seq_model.sv
// Sequencer and interrupt logic model issuing stack operations
`timescale 1ns/1ps
module rasu_seq_model (
   input wire i_sys_clk,
   output reg o_push_call,
   output reg o_push_int,
   output reg o_int_high,
   output reg o_push_instr,
   output reg o_pop_ret,
   output reg o_pop_instr,
   output reg o_fast,
   output reg [20:0] o_pc,
   output reg [7:0] o_status,
   output reg [7:0] o_working_register,
   output reg [7:0] o_bsr
);
   initial begin
      {o_push_call, o_push_int, o_int_high, o_push_instr, o_pop_ret, o_pop_instr, o_fast} = 7'h00;
      o_pc = 21'h000000;
      {o_status, o_working_register, o_bsr} = 24'h000000;
   end
   // One operation per call, never during top-entry access
   task op(input [2:0] k, input [20:0] pc, input f);
      begin
         @(posedge i_sys_clk);
         o_push_call <= (k == 3'h1);
         o_push_int <= (k == 3'h2) || (k == 3'h3);
         o_int_high <= (k == 3'h2);
         o_push_instr <= (k == 3'h4);
         o_pop_ret <= (k == 3'h5);
         o_pop_instr <= (k == 3'h6);
         o_fast <= f;
         o_pc <= pc;
         {o_bsr, o_working_register, o_status} <= {3'h0, pc};
         @(posedge i_sys_clk);
         {o_push_call, o_push_int, o_push_instr, o_pop_ret, o_pop_instr, o_fast} <= 6'h00;
         // Released lines carry no stale value
         o_pc <= ~pc;
         {o_bsr, o_working_register, o_status} <= ~{3'h0, pc};
      end
   endtask
endmodule

// File: verif/rasu_top_sva.sv
// Port assertions for the return stack unit
`timescale 1ns/1ps
module rasu_top_sva #(
   parameter [20:0] IMPL_BYTES = 21'h008000
) (
   input wire i_sys_clk,
   input wire i_reset_n,
   input wire i_dev_reset,
   input wire [4:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] o_avs_readdata,
   input wire o_avs_waitrequest,
   input wire i_push_call,
   input wire i_push_int,
   input wire i_int_high,
   input wire i_push_instr,
   input wire i_pop_ret,
   input wire i_pop_instr,
   input wire i_fast,
   input wire [20:0] i_fetch_addr,
   input wire [15:0] o_fetch_word,
   input wire o_pc_load,
   input wire [20:0] o_pc_value,
   input wire o_stack_reset,
   input wire o_restore
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   wire any_push = i_push_call || i_push_int || i_push_instr;
   chk_fetch_high: assert property (i_fetch_addr >= IMPL_BYTES |=> o_fetch_word == 16'h0000)
      else $error("fetch above memory not zero");
   chk_int_vector: assert property (i_push_int && !i_push_call && !i_push_instr && !i_dev_reset && !o_stack_reset |=>
      o_stack_reset || (o_pc_load && o_pc_value == ($past(i_int_high) ? 21'h000008 : 21'h000018)))
      else $error("interrupt vector wrong");
   chk_ret_load: assert property (i_pop_ret && !any_push && !i_dev_reset |=> o_pc_load || o_stack_reset)
      else $error("return did not load counter");
   chk_fault_seq: assert property (o_stack_reset && !i_dev_reset |=> o_pc_load && o_pc_value == 21'h000000)
      else $error("fault reset not followed by load of zero");
   chk_pop_noload: assert property (i_pop_instr && !i_pop_ret && !any_push && !o_stack_reset |=> !o_pc_load)
      else $error("pop instruction loaded counter");
   chk_fast_restore: assert property (o_restore |-> $past(i_pop_ret && i_fast))
      else $error("restore without fast return");
   chk_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest && $past(o_avs_waitrequest)
      |=> !o_avs_waitrequest)
      else $error("bus answer late");
   chk_ptr_bits: assert property (!o_avs_waitrequest && $past(i_avs_read && i_avs_address == 5'h00) |->
      o_avs_readdata[5] == 1'b0 && o_avs_readdata[31:8] == 24'h000000)
      else $error("pointer register reserved bits set");
   cover property (o_stack_reset);
   cover property (o_restore);
   cover property (i_push_int && i_int_high);
endmodule
bind rasu_top rasu_top_sva #(.IMPL_BYTES(IMPL_BYTES)) u_sva (.*);

// File: verif/return_address_stack_unit_test.sv
// Self-checking bench for the return stack unit
`timescale 1ns/1ps
module return_address_stack_unit_test;
   reg i_sys_clk = 1'b0;
   reg i_reset_n = 1'b0;
   reg i_dev_reset = 1'b0;
   reg [4:0] i_avs_address = 5'h00;
   reg i_avs_read = 1'b0;
   reg i_avs_write = 1'b0;
   reg [31:0] i_avs_writedata = 32'h0;
   wire [3:0] i_avs_byteenable = 4'hf;
   reg [20:0] i_fetch_addr = 21'h008000;
   reg [15:0] i_fetch_word = 16'hbeef;
   wire [31:0] o_avs_readdata;
   wire o_avs_waitrequest, o_pc_load, o_stack_reset, o_restore;
   wire i_push_call, i_push_int, i_int_high, i_push_instr, i_pop_ret, i_pop_instr, i_fast;
   wire [20:0] i_pc, o_pc_value;
   wire [7:0] i_status, i_working_register, i_bsr, o_status, o_working_register, o_bsr;
   wire [15:0] o_fetch_word;
   integer n_fail = 0;
   integer checks = 0;
   always #5 i_sys_clk = ~i_sys_clk;
   rasu_top uut (.*);
   rasu_seq_model seq (.i_sys_clk(i_sys_clk), .o_push_call(i_push_call), .o_push_int(i_push_int),
      .o_int_high(i_int_high), .o_push_instr(i_push_instr), .o_pop_ret(i_pop_ret),
      .o_pop_instr(i_pop_instr), .o_fast(i_fast), .o_pc(i_pc), .o_status(i_status),
      .o_working_register(i_working_register), .o_bsr(i_bsr));
   task chk(input [31:0] g, input [31:0] e);
      begin
         checks = checks + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task bus(input w, input [4:0] a, input [7:0] d, output [31:0] q);
      integer n;
      begin
         n = 0;
         @(posedge i_sys_clk);
         i_avs_address <= a;
         i_avs_read <= !w;
         i_avs_write <= w;
         i_avs_writedata <= {24'h0, d};
         do begin
            @(posedge i_sys_clk);
            n = n + 1;
         end while (o_avs_waitrequest !== 1'b0 && n < 20);
         q = o_avs_readdata;
         i_avs_read <= 1'b0;
         i_avs_write <= 1'b0;
         if (n >= 20) n_fail = n_fail + 1;
      end
   endtask
   task rd(input [4:0] a, input [31:0] e);
      reg [31:0] q;
      begin
         bus(1'b0, a, 8'h00, q);
         chk(q, e);
      end
   endtask
   task wr(input [4:0] a, input [7:0] d);
      reg [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task rdtos(input [20:0] e);
      begin
         rd(5'h04, {27'h0, e[20:16]});
         rd(5'h08, {24'h0, e[15:8]});
         rd(5'h0c, {24'h0, e[7:0]});
      end
   endtask
   task ret(input f, input [20:0] e);
      begin
         seq.op(3'h5, 21'h000000, f);
         #1;
         chk({31'h0, o_pc_load}, 32'h1);
         chk({11'h0, o_pc_value}, {11'h0, e});
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d n_fail %0d", checks, n_fail);
         if (n_fail == 0 && checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   initial begin
      #100000;
      n_fail = n_fail + 1;
      print_verdict;
   end
   initial begin
      repeat (20) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      rd(5'h00, 32'h0);
      rd(5'h10, 32'h1);
      rd(5'h14, 32'h0);
      chk({16'h0, o_fetch_word}, 32'h0);
      i_fetch_addr <= 21'h007ffe;
      @(posedge i_sys_clk);
      #1 chk({16'h0, o_fetch_word}, 32'h0000beef);
      $display("test reset and fetch done");
      seq.op(3'h1, 21'h012344, 1'b0);
      seq.op(3'h3, 21'h0a1b2c, 1'b0);
      #1 chk({11'h0, o_pc_value}, 32'h18);
      seq.op(3'h4, 21'h1f0ffe, 1'b0);
      rd(5'h00, 32'h3);
      rdtos(21'h1f0ffe);
      wr(5'h0c, 8'h5a);
      rdtos(21'h1f0f5a);
      seq.op(3'h6, 21'h000000, 1'b0);
      #1 chk({31'h0, o_pc_load}, 32'h0);
      seq.op(3'h2, 21'h033d4e, 1'b0);
      #1 chk({11'h0, o_pc_value}, 32'h8);
      seq.op(3'h6, 21'h000000, 1'b0);
      ret(1'b1, 21'h0a1b2c);
      chk({o_restore, o_bsr, o_working_register, o_status}, 32'h01033d4e);
      seq.op(3'h1, 21'h055667, 1'b1);
      ret(1'b1, 21'h055667);
      chk({o_restore, o_bsr, o_working_register, o_status}, 32'h01055667);
      ret(1'b0, 21'h012344);
      rd(5'h00, 32'h0);
      $display("test push and pop done");
      wr(5'h10, 8'h00);
      ret(1'b0, 21'h000000);
      rd(5'h00, 32'h40);
      wr(5'h00, 8'h00);
      rd(5'h00, 32'h0);
      wr(5'h00, 8'h1d);
      seq.op(3'h1, 21'h000100, 1'b0);
      seq.op(3'h1, 21'h000200, 1'b0);
      seq.op(3'h1, 21'h000300, 1'b0);
      rd(5'h00, 32'h9f);
      rdtos(21'h000200);
      @(posedge i_sys_clk);
      i_dev_reset <= 1'b1;
      @(posedge i_sys_clk);
      i_dev_reset <= 1'b0;
      rd(5'h00, 32'h80);
      $display("test full and underflow done");
      wr(5'h10, 8'h01);
      wr(5'h00, 8'h1e);
      seq.op(3'h1, 21'h000400, 1'b0);
      #1 chk({31'h0, o_stack_reset}, 32'h1);
      rd(5'h00, 32'h80);
      wr(5'h00, 8'h9f);
      rd(5'h00, 32'h9f);
      rdtos(21'h000402);
      wr(5'h00, 8'h00);
      seq.op(3'h6, 21'h000000, 1'b0);
      #1 chk({31'h0, o_stack_reset}, 32'h1);
      rd(5'h00, 32'h40);
      $display("test fault reset done");
      print_verdict;
   end
endmodule
